// ==== logic/uhc_list_ctrl.sv ====
// Overview of operation
// RL1: control-to-bulk ratio compared with served count; count survives frame boundaries.
// RL2: periodic enable sampled at frame start; cleared bit stops list next frame.
// RL3: iso ed with iso disabled halts periodic list; enable applies next frame.
// RL4: control and bulk enables sampled at frame start before serving a list.
// RL5: software edits a list only while disabled and fixes its pointer.
// RL6: functional state encoding 00 reset, 01 resume, 10 operational, 11 suspend.
// RL7: entering operational starts frame generation one millisecond later.
// RL8: hardware moves state only from suspend to resume on resume signaling.
// RL9: soft reset gives suspend; hard reset gives reset state and hub reset.
// RL10: routing bit steers interrupts to normal or management line; survives soft reset.
// RL11: wake supported bit cleared by hard reset, kept over soft reset.
// RL12: wake enable with resume event signals wakeup; no effect on interrupts.
// RL13: command register is write-to-set, fully readable.
// RL14: reset command: suspend, reset registers, block bus, self-clear well within 10 ms.
// RL15: filled flag gates list head, cleared on start, set when td found.
// RL16: ownership request sets ownership event, which raises management interrupt.
// RL17: two-bit overrun counter increments on every overrun and wraps.
// RL18: status bits set by hardware, cleared by writing one; fatal bit reads 0.
// RL19: interrupt when status bit, its enable and global enable are all set.
// RL20: frame start event each frame; wrap event on every frame bit 15 toggle.
// RL21: done-written event set after write; further writes held until cleared.
// RL22: resume event on rising resume signaling only, never on software state write.
// RL23: hub change event on hub status change; overrun event on schedule overrun.
//
// Purpose: control, command and interrupt status registers of a usb host controller
// Assumes: engine inputs synchronous to I_MCLK; strobes one cycle, never together
// Notes:   read data is registered and valid in the cycle after the read strobe
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module uhc_list_ctrl
    import uhc_pkg::*;
#(
    parameter int unsigned SOF_DELAY = uhc_pkg::SOF_DELAY_CYC
)(
    input  wire logic                  I_MCLK,
    input  wire logic                  I_RESETN,
    input  wire logic [7:0]            I_ADDR,
    input  wire logic [31:0]           I_WDATA,
    input  wire logic                  I_WR,
    input  wire logic                  I_RD,
    output logic      [31:0]           O_RDATA,
    input  wire uhc_pkg::uhc_eng_in_t  I_ENG,
    output uhc_pkg::uhc_eng_out_t      O_ENG,
    output logic                       O_IRQ,
    output logic                       O_SMI,
    output logic                       O_WAKE
);
    import uhc_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [1:0]   ratio_q;
    logic         periodic_en_q, iso_en_q, ctrl_list_en_q, bulk_list_en_q;
    uhc_state_t   func_state_q, func_state_d;
    logic         irq_route_sel_q, wake_supported_q, wake_en_q;
    logic         soft_reset_cmd_q, ctrl_filled_q, bulk_filled_q, owner_req_q;
    logic [1:0]   overrun_cnt_q;
    logic [31:0]  status_q, status_d, status_set;
    logic [31:0]  mask_q;
    logic [4:0]   srst_cnt_q;
    logic [13:0]  sof_cnt_q;
    logic         sof_en_q;
    logic         periodic_run_q, iso_frame_q, ctrl_run_q, bulk_run_q;
    logic [2:0]   ctrl_cnt_q;
    logic         msb_prev_q, resume_prev_q;
    logic [31:0]  rdata_q;

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    wire        bus_blocked  = soft_reset_cmd_q;                           // RL14
    wire        wr_ok        = I_WR && !bus_blocked;
    wire        wr_ctl       = wr_ok && (I_ADDR == OFS_OPER_CTRL);
    wire        wr_cmd       = wr_ok && (I_ADDR == OFS_CMD_STATUS);
    wire        wr_sts       = wr_ok && (I_ADDR == OFS_INT_STATUS);
    wire        wr_mset      = wr_ok && (I_ADDR == OFS_MASK_SET);
    wire        wr_mclr      = wr_ok && (I_ADDR == OFS_MASK_CLR);
    wire        srst_start   = wr_cmd && I_WDATA[CMD_SRST];
    wire        srst_active  = soft_reset_cmd_q;
    wire        srst_done    = srst_active && (srst_cnt_q == 5'h01);
    wire [1:0]  wr_state     = I_WDATA[CTL_STATE_LO +: 2];

    // ---------------------------------------------------------------
    // read data words
    // ---------------------------------------------------------------
    wire [31:0] ctl_word = {21'h000000, wake_en_q, wake_supported_q, irq_route_sel_q,
                            func_state_q, bulk_list_en_q, ctrl_list_en_q,
                            iso_en_q, periodic_en_q, ratio_q};
    wire [31:0] cmd_word = {14'h0000, overrun_cnt_q, 12'h000, owner_req_q,
                            bulk_filled_q, ctrl_filled_q, soft_reset_cmd_q};  // RL13
    wire [31:0] rd_mux   = (I_ADDR == OFS_OPER_CTRL)  ? ctl_word :
                           (I_ADDR == OFS_CMD_STATUS) ? cmd_word :
                           (I_ADDR == OFS_INT_STATUS) ? status_q :
                           (I_ADDR == OFS_MASK_SET)   ? mask_q   :
                           (I_ADDR == OFS_MASK_CLR)   ? mask_q   : 32'h0000_0000;

    // ---------------------------------------------------------------
    // event detection
    // ---------------------------------------------------------------
    wire resume_rise = I_ENG.resume_signal && !resume_prev_q;             // RL22
    wire msb_toggle  = I_ENG.frame_msb != msb_prev_q;                      // RL20
    wire owner_set   = wr_cmd && I_WDATA[CMD_OWNER_REQ];                   // RL16

    // hardware set terms per status bit; the fatal bit never sets
    always_comb
    begin
        status_set                 = 32'h0000_0000;
        status_set[ST_OVERRUN]     = I_ENG.overrun;                        // RL23
        status_set[ST_DONE_WR]     = I_ENG.done_written;                   // RL21
        status_set[ST_FRAME_START] = I_ENG.frame_start;                    // RL20
        status_set[ST_RESUME]      = resume_rise;                          // RL22
        status_set[ST_FRAME_WRAP]  = I_ENG.frame_start && msb_toggle;      // RL20
        status_set[ST_HUB_CHANGE]  = I_ENG.hub_change;                     // RL23
        status_set[ST_OWNER]       = owner_set;                            // RL16
    end

    // write-one clears, set wins over clear in the same cycle
    always_comb
    begin
        status_d = (status_q & ~(wr_sts ? I_WDATA : 32'h0000_0000)) | status_set;  // RL18
        status_d = status_d & ST_IMPL_BITS;                                // RL18
    end

    // ---------------------------------------------------------------
    // functional state
    // ---------------------------------------------------------------
    always_comb
    begin
        func_state_d = func_state_q;
        if (wr_ctl)
        begin
            func_state_d = uhc_state_t'(wr_state);                         // RL6
        end
        else if (func_state_q == FS_SUSPEND && resume_rise)
        begin
            func_state_d = FS_RESUME;                                      // RL8
        end
    end

    // ---------------------------------------------------------------
    // operating control register
    // ---------------------------------------------------------------
    // routing and wake-supported survive the soft reset
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            irq_route_sel_q  <= CTL_RESET_VAL[CTL_ROUTE];                  // RL10
            wake_supported_q <= CTL_RESET_VAL[CTL_WAKE_SUP];               // RL11
        end
        else if (wr_ctl)
        begin
            irq_route_sel_q  <= I_WDATA[CTL_ROUTE];                        // RL10
            wake_supported_q <= I_WDATA[CTL_WAKE_SUP];                     // RL11
        end
    end

    // fields that a soft reset clears, and the state that it forces to suspend
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            ratio_q        <= CTL_RESET_VAL[CTL_RATIO_LO +: 2];
            periodic_en_q  <= 1'b0;
            iso_en_q       <= 1'b0;
            ctrl_list_en_q <= 1'b0;
            bulk_list_en_q <= 1'b0;
            wake_en_q      <= 1'b0;
            func_state_q   <= FS_RESET;                                    // RL9
        end
        else if (srst_active || srst_start)
        begin
            ratio_q        <= 2'h0;                                        // RL14
            periodic_en_q  <= 1'b0;
            iso_en_q       <= 1'b0;
            ctrl_list_en_q <= 1'b0;
            bulk_list_en_q <= 1'b0;
            wake_en_q      <= 1'b0;
            func_state_q   <= FS_SUSPEND;                                  // RL9
        end
        else
        begin
            if (wr_ctl)
            begin
                ratio_q        <= I_WDATA[CTL_RATIO_LO +: 2];
                periodic_en_q  <= I_WDATA[CTL_PERIODIC];
                iso_en_q       <= I_WDATA[CTL_ISO];
                ctrl_list_en_q <= I_WDATA[CTL_CTRL_LIST];
                bulk_list_en_q <= I_WDATA[CTL_BULK_LIST];
                wake_en_q      <= I_WDATA[CTL_WAKE_EN];
            end
            func_state_q <= func_state_d;
        end
    end

    // ---------------------------------------------------------------
    // command register
    // ---------------------------------------------------------------
    // software only sets; hardware clears on completion or list start
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            soft_reset_cmd_q <= 1'b0;
            srst_cnt_q       <= 5'h00;
            ctrl_filled_q    <= 1'b0;
            bulk_filled_q    <= 1'b0;
            owner_req_q      <= 1'b0;
            overrun_cnt_q    <= 2'h0;
        end
        else if (srst_active)
        begin
            soft_reset_cmd_q <= !srst_done;                                // RL14
            srst_cnt_q       <= srst_cnt_q - 5'h01;
            ctrl_filled_q    <= 1'b0;
            bulk_filled_q    <= 1'b0;
            owner_req_q      <= 1'b0;
            overrun_cnt_q    <= 2'h0;
        end
        else
        begin
            if (srst_start)
            begin
                soft_reset_cmd_q <= 1'b1;                                  // RL14
                srst_cnt_q       <= SRST_CYC;
            end
            // set wins: td found or a software write beats the head clear
            ctrl_filled_q <= (ctrl_filled_q && !(I_ENG.ctrl_head && O_ENG.ctrl_head_go))
                             || I_ENG.ctrl_td_found
                             || (wr_cmd && I_WDATA[CMD_CTRL_FILL]);       // RL15
            bulk_filled_q <= (bulk_filled_q && !(I_ENG.bulk_head && O_ENG.bulk_head_go))
                             || I_ENG.bulk_td_found
                             || (wr_cmd && I_WDATA[CMD_BULK_FILL]);       // RL15
            owner_req_q   <= (owner_req_q && !I_ENG.owner_done) || owner_set;  // RL16
            if (I_ENG.overrun)
            begin
                overrun_cnt_q <= overrun_cnt_q + 2'h1;                     // RL17
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt status and mask
    // ---------------------------------------------------------------
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN || srst_active)
        begin
            status_q <= 32'h0000_0000;
            mask_q   <= 32'h0000_0000;
        end
        else
        begin
            status_q <= status_d;
            mask_q   <= (mask_q | (wr_mset ? I_WDATA : 32'h0000_0000))
                        & ~(wr_mclr ? I_WDATA : 32'h0000_0000) & MASK_IMPL_BITS;
        end
    end

    // ---------------------------------------------------------------
    // frame timing and list permissions
    // ---------------------------------------------------------------
    wire entering_op = (func_state_d == FS_OPERATIONAL) && (func_state_q != FS_OPERATIONAL);

    // frame generation starts a fixed delay after becoming operational
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN || srst_active || func_state_q != FS_OPERATIONAL)
        begin
            sof_cnt_q <= entering_op ? 14'(SOF_DELAY - 1) : 14'h0000;      // RL7
            sof_en_q  <= 1'b0;
        end
        else if (sof_cnt_q != 14'h0000)
        begin
            sof_cnt_q <= sof_cnt_q - 14'h0001;                             // RL7
        end
        else
        begin
            sof_en_q <= 1'b1;                                              // RL7
        end
    end

    // enables are taken at each frame start; iso halt lasts to frame end
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN || srst_active)
        begin
            periodic_run_q <= 1'b0;
            iso_frame_q    <= 1'b0;
            ctrl_run_q     <= 1'b0;
            bulk_run_q     <= 1'b0;
        end
        else if (I_ENG.frame_start)
        begin
            periodic_run_q <= periodic_en_q;                               // RL2
            iso_frame_q    <= iso_en_q;                                    // RL3
            ctrl_run_q     <= ctrl_list_en_q;                              // RL4
            bulk_run_q     <= bulk_list_en_q;                              // RL4
        end
        else if (I_ENG.iso_ed_seen && !iso_frame_q)
        begin
            periodic_run_q <= 1'b0;                                        // RL3
        end
    end

    // served control count kept across frames, cleared when bulk gets a turn
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN || srst_active)
        begin
            ctrl_cnt_q <= 3'h0;
        end
        else if (I_ENG.bulk_ed_served)
        begin
            ctrl_cnt_q <= 3'h0;                                            // RL1
        end
        else if (I_ENG.ctrl_ed_served && ctrl_cnt_q != 3'h4)
        begin
            ctrl_cnt_q <= ctrl_cnt_q + 3'h1;                               // RL1
        end
    end

    // ---------------------------------------------------------------
    // edge history and read data
    // ---------------------------------------------------------------
    always_ff @(posedge I_MCLK)
    begin
        if (!I_RESETN)
        begin
            msb_prev_q    <= 1'b0;
            resume_prev_q <= 1'b0;
            rdata_q       <= 32'h0000_0000;
        end
        else
        begin
            if (I_ENG.frame_start)
            begin
                msb_prev_q <= I_ENG.frame_msb;
            end
            resume_prev_q <= I_ENG.resume_signal;
            rdata_q       <= I_RD ? rd_mux : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    wire [31:0] pending  = status_q & mask_q;
    wire        irq_any  = mask_q[MASK_GLOBAL] && (|pending[30:0]);        // RL19

    assign O_RDATA              = rdata_q;
    assign O_IRQ                = irq_any && !irq_route_sel_q;             // RL10
    assign O_SMI                = (irq_any && irq_route_sel_q) || pending[ST_OWNER];  // RL16
    assign O_WAKE               = wake_en_q && status_q[ST_RESUME];        // RL12
    assign O_ENG.func_state     = func_state_q;
    assign O_ENG.sof_en         = sof_en_q;
    assign O_ENG.periodic_run   = periodic_run_q;                          // RL2
    assign O_ENG.ctrl_run       = ctrl_run_q;
    assign O_ENG.bulk_run       = bulk_run_q;
    assign O_ENG.ctrl_head_go   = ctrl_run_q && ctrl_filled_q;             // RL15
    assign O_ENG.bulk_head_go   = bulk_run_q && bulk_filled_q;             // RL15
    assign O_ENG.serve_ctrl     = ctrl_cnt_q <= {1'b0, ratio_q};           // RL1
    assign O_ENG.done_write_ok  = !status_q[ST_DONE_WR];                   // RL21
    assign O_ENG.hub_reset      = func_state_q == FS_RESET;                // RL9
    assign O_ENG.bus_blocked    = bus_blocked;

endmodule

`default_nettype wire

// ==== logic/uhc_pkg.sv ====
// Purpose: constants, register map and carrier types of the usb host list control block
// Assumes: 10 MHz clock, byte addresses on an 8-bit register address
// Notes:   registers take one aligned 32-bit word each
package uhc_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 100;
    localparam int unsigned SOF_DELAY_NS     = 1000000;                     // 1 ms
    localparam int unsigned SOF_DELAY_CYC    = SOF_DELAY_NS / CLK_PERIOD_NS;
    localparam int unsigned SRST_MAX_NS      = 10000000;                    // 10 ms ceiling
    localparam logic [4:0]  SRST_CYC         = 5'h10;                       // well inside ceiling

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_OPER_CTRL   = 8'h04;
    localparam logic [7:0] OFS_CMD_STATUS  = 8'h08;
    localparam logic [7:0] OFS_INT_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_MASK_SET    = 8'h10;
    localparam logic [7:0] OFS_MASK_CLR    = 8'h14;

    // ---------------------------------------------------------------
    // operating_control fields
    // ---------------------------------------------------------------
    localparam int unsigned CTL_RATIO_LO   = 0;
    localparam int unsigned CTL_PERIODIC   = 2;
    localparam int unsigned CTL_ISO        = 3;
    localparam int unsigned CTL_CTRL_LIST  = 4;
    localparam int unsigned CTL_BULK_LIST  = 5;
    localparam int unsigned CTL_STATE_LO   = 6;
    localparam int unsigned CTL_ROUTE      = 8;
    localparam int unsigned CTL_WAKE_SUP   = 9;
    localparam int unsigned CTL_WAKE_EN    = 10;
    localparam logic [10:0] CTL_RESET_VAL  = 11'h000;

    // ---------------------------------------------------------------
    // command_status fields
    // ---------------------------------------------------------------
    localparam int unsigned CMD_SRST       = 0;
    localparam int unsigned CMD_CTRL_FILL  = 1;
    localparam int unsigned CMD_BULK_FILL  = 2;
    localparam int unsigned CMD_OWNER_REQ  = 3;
    localparam int unsigned CMD_OVR_LO     = 16;

    // ---------------------------------------------------------------
    // interrupt_status / mask fields
    // ---------------------------------------------------------------
    localparam int unsigned ST_OVERRUN     = 0;
    localparam int unsigned ST_DONE_WR     = 1;
    localparam int unsigned ST_FRAME_START = 2;
    localparam int unsigned ST_RESUME      = 3;
    localparam int unsigned ST_FATAL       = 4;
    localparam int unsigned ST_FRAME_WRAP  = 5;
    localparam int unsigned ST_HUB_CHANGE  = 6;
    localparam int unsigned ST_OWNER       = 30;
    localparam int unsigned MASK_GLOBAL    = 31;
    localparam logic [31:0] ST_IMPL_BITS   = 32'h4000_006f;
    localparam logic [31:0] MASK_IMPL_BITS = 32'hc000_006f;

    // functional states, order fixes 00b reset .. 11b suspend
    typedef enum logic [1:0] {
        FS_RESET, FS_RESUME, FS_OPERATIONAL, FS_SUSPEND
    } uhc_state_t;

    // events and requests from the schedule engine and root hub
    typedef struct packed {
        logic frame_start;     // pulse: frame number updated, frame token sent
        logic frame_msb;       // level: bit 15 of frame_num
        logic overrun;         // pulse: schedule overran this frame
        logic done_written;    // pulse: done head copied to shared memory
        logic resume_signal;   // level: downstream port signals resume
        logic hub_change;      // pulse: hub or port status changed
        logic ctrl_head;       // pulse: engine at head of control list
        logic bulk_head;       // pulse: engine at head of bulk list
        logic ctrl_td_found;   // pulse: td found on control list
        logic bulk_td_found;   // pulse: td found on bulk list
        logic ctrl_ed_served;  // pulse: non-empty control ed served
        logic bulk_ed_served;  // pulse: bulk ed served
        logic iso_ed_seen;     // pulse: isochronous ed met in periodic list
        logic owner_done;      // pulse: ownership changeover finished
    } uhc_eng_in_t;

    // permissions and state towards the schedule engine
    typedef struct packed {
        logic [1:0] func_state;
        logic       sof_en;
        logic       periodic_run;
        logic       ctrl_run;
        logic       bulk_run;
        logic       ctrl_head_go;
        logic       bulk_head_go;
        logic       serve_ctrl;
        logic       done_write_ok;
        logic       hub_reset;
        logic       bus_blocked;
    } uhc_eng_out_t;

endpackage

// ==== verif/test_usb_host_list_control_status.sv ====
// Purpose: self-checking bench for uhc_list_ctrl
// Assumes: 10 MHz clock, short frame-start delay
// Notes:   bus access via wr and rd
`timescale 1ns/100ps
`default_nettype none
module test_usb_host_list_control_status;
    import uhc_pkg::*;
    localparam int unsigned SOF_D = 20;
    logic        i_mclk, i_resetn, i_wr, i_rd, o_irq, o_smi, o_wake;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata;
    uhc_eng_in_t  eng_in;
    uhc_eng_out_t eng_out;
    int          err_total = 0, n_checks = 0, n;
    logic [7:0]  ofs_list [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
    uhc_list_ctrl #(.SOF_DELAY(SOF_D)) dut (.I_MCLK(i_mclk), .I_RESETN(i_resetn),
        .I_ADDR(i_addr), .I_WDATA(i_wdata), .I_WR(i_wr), .I_RD(i_rd), .O_RDATA(o_rdata),
        .I_ENG(eng_in), .O_ENG(eng_out), .O_IRQ(o_irq), .O_SMI(o_smi), .O_WAKE(o_wake));
    uhc_eng_model eng (.i_clk(i_mclk), .i_ctl(eng_out), .o_eng(eng_in));
    initial
    begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // compare, access and closing tasks
    task chk(input string s, input logic [31:0] g, e);
        n_checks++;
        if (g !== e) err_total++;
        if (g !== e) $display("[ERR] %s exp %h got %h", s, e, g);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_mclk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk("rdata", o_rdata, e);
    endtask
    task report_and_stop;
        if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        {i_resetn, i_wr, i_rd, i_addr, i_wdata} = '0;
        repeat (12) @(posedge i_mclk);
        i_resetn <= 1'b1;
        foreach (ofs_list[k]) rd(ofs_list[k], 32'h0);
        chk("hub_reset", eng_out.hub_reset, 1);
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h0000_07ff);
        eng.ev(14'h0200);
        rd(8'h0c, 32'h8);
        chk("wake", {eng_out.func_state, o_wake, o_irq}, 4'h6);
        wr(8'h0c, 32'h8);
        rd(8'h0c, 32'h0);
        eng.ev(14'h0);
        wr(8'h08, 32'h6);
        wr(8'h08, 32'h0);
        rd(8'h08, 32'h6);
        wr(8'h10, 32'h4000_0000);
        wr(8'h08, 32'h8);
        rd(8'h0c, 32'h4000_0000);
        chk("smi", o_smi, 1);
        eng.ev(14'h0001);
        rd(8'h08, 32'h6);
        eng.ev(14'h2000);
        chk("head_go", eng_out.ctrl_head_go, 1);
        eng.ev(14'h0080);
        chk("head_go", eng_out.ctrl_head_go, 0);
        eng.ev(14'h0070);
        repeat (5) eng.ev(14'h0800);
        rd(8'h08, 32'h0001_0006);
        wr(8'h0c, 32'hffff_ffff);
        eng.ev(14'h3000);
        eng.ev(14'h1500);
        rd(8'h0c, 32'h66);
        chk("done_ok", eng_out.done_write_ok, 0);
        wr(8'h10, 32'h8000_0040);
        chk("irq_smi", {o_irq, o_smi}, 2'b01);
        wr(8'h04, 32'h0000_00bc);
        for (n = 0; n < 99 && eng_out.sof_en !== 1'b1; n++) @(posedge i_mclk) #1;
        chk("sof_delay", n, SOF_D);
        chk("irq_smi", {o_irq, o_smi}, 2'b10);
        chk("serve", eng_out.serve_ctrl, 1);
        eng.ev(14'h0008);
        chk("serve", eng_out.serve_ctrl, 0);
        wr(8'h04, 32'h0000_0304);
        eng.ev(14'h2000);
        chk("eng", eng_out, 12'h102);
        eng.ev(14'h0006);
        chk("eng", eng_out, 12'h00a);
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h1);
        wr(8'h04, 32'h0);
        repeat (20) @(posedge i_mclk);
        rd(8'h04, 32'h0000_03c0);
        rd(8'h10, 32'h0);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        rd(8'h04, 32'h0);
        report_and_stop;
    end
endmodule
`default_nettype wire

// ==== verif/uhc_eng_model.sv ====
// Purpose: schedule engine and downstream port stand-in
// Assumes: driven by the bench through its event task
// Notes:   pulses last one clock, resume and frame msb levels hold
`timescale 1ns/100ps
`default_nettype none
module uhc_eng_model (
    input  wire logic                  i_clk,
    input  wire uhc_pkg::uhc_eng_out_t i_ctl,
    output uhc_pkg::uhc_eng_in_t       o_eng
);
    import uhc_pkg::*;
    initial o_eng = '0;
    // one-cycle event; no done write while the last one is pending
    task automatic ev(input uhc_eng_in_t p);
        @(posedge i_clk);
        o_eng <= p & {3'h7, i_ctl.done_write_ok, 10'h3ff};
        @(posedge i_clk);
        o_eng <= p & 14'h1200;
        #1;
    endtask
endmodule
`default_nettype wire

// ==== verif/uhc_list_ctrl_sva.sv ====
// Purpose: port assertions for uhc_list_ctrl
// Assumes: one clock, synchronous active-low reset
// Notes:   attached by the bind below
`timescale 1ns/100ps
`default_nettype none
module uhc_list_ctrl_sva #(
    parameter int unsigned SOF_DELAY = uhc_pkg::SOF_DELAY_CYC
)(
    input wire logic                  I_MCLK,
    input wire logic                  I_RESETN,
    input wire logic [7:0]            I_ADDR,
    input wire logic [31:0]           I_WDATA,
    input wire logic                  I_WR,
    input wire logic                  I_RD,
    input wire logic [31:0]           O_RDATA,
    input wire uhc_pkg::uhc_eng_in_t  I_ENG,
    input wire uhc_pkg::uhc_eng_out_t O_ENG,
    input wire logic                  O_IRQ,
    input wire logic                  O_SMI,
    input wire logic                  O_WAKE
);
    import uhc_pkg::*;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    // read data, state, soft reset, done write, frame start and filled flag relations
    AST_RD_IDLE: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
        else $error("read data not zero");
    AST_FATAL: assert property ($past(I_RD) && $past(I_ADDR) == 8'h0c |-> !O_RDATA[ST_FATAL])
        else $error("fatal bit read as one");
    AST_HUB_RST: assert property (O_ENG.hub_reset == (O_ENG.func_state == 2'b00))
        else $error("hub reset mismatch");
    AST_SRST_ST: assert property (O_ENG.bus_blocked |-> O_ENG.func_state == 2'b11)
        else $error("not suspended in soft reset");
    AST_SRST_LEN: assert property ($rose(O_ENG.bus_blocked) |-> O_ENG.bus_blocked [*8] ##[1:12] !O_ENG.bus_blocked)
        else $error("soft reset length wrong");
    AST_DONE_OK: assert property ($fell(O_ENG.done_write_ok) |-> $past(I_ENG.done_written))
        else $error("done write blocked");
    AST_STATE_HW: assert property ($changed(O_ENG.func_state) && !$past(I_WR) && $past(I_RESETN)
        |-> $past(O_ENG.func_state) == 2'b11 && O_ENG.func_state == 2'b01)
        else $error("illegal hardware state change");
    AST_SOF_OP: assert property ($rose(O_ENG.sof_en) |-> O_ENG.func_state == 2'b10 && $stable(O_ENG.func_state))
        else $error("sof outside operational");
    AST_HEAD_GO: assert property (I_ENG.ctrl_head && O_ENG.ctrl_head_go && !I_ENG.ctrl_td_found && !I_WR
        |=> !O_ENG.ctrl_head_go)
        else $error("filled flag kept at head");
endmodule
bind uhc_list_ctrl uhc_list_ctrl_sva #(.SOF_DELAY(SOF_DELAY)) u_sva (
    .I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_ENG(I_ENG), .O_ENG(O_ENG),
    .O_IRQ(O_IRQ), .O_SMI(O_SMI), .O_WAKE(O_WAKE));
`default_nettype wire
